// file: design/cttg_pkg.sv
// Constants, port map and helper functions of the CRT timing generator.
// Assumes a 16-bit host I/O port decoder and one nugget-rate clock.
// Behaviour
// - Hblank starts after displayed count plus one
// - Hsync starts after start plus one, if below total
// - Hsync lasts width groups, not cut at line end
// - Hsync polarity bit: one negative, zero positive
// - Vertical counter steps per line, or half-line interlaced
// - Vertical total is modulus times base plus adjust plus one
// - Scan modulus from double scan and lines-per-row code
// - Vblank starts at displayed count, aligned to line end
// - Interlaced vblank shifts by half line per frame
// - Vsync starts at computed count, not line aligned
// - Vsync lasts width lines or half-lines, total ignored
// - Vsync polarity bit: one negative, zero positive
// - Lines-per-row code and double scan select a scan modulus of two to sixteen steps
// - Control bit 3 double scan, bit 4 interlace
// - Line lasts total plus one groups
// - Enable bits set or clear a latch, read in bit 5
package cttg_pkg;

    localparam int          NREG      = 9;
    localparam logic [15:0] RST_VAL   = 16'h0000;
    // Register slots: 0 horiz total, then the eight mapped timing registers
    localparam logic [15:0] WR_ADDR [NREG] = '{16'h02E8, 16'h06E8, 16'h0AE8,
        16'h0EE8, 16'h12E8, 16'h16E8, 16'h1AE8, 16'h1EE8, 16'h22E8};
    localparam logic [15:0] RD_ADDR [NREG] = '{16'h26E8, 16'h06E8, 16'h0AE8,
        16'h0EE8, 16'h12E8, 16'h16E8, 16'h1AE8, 16'h1EE8, 16'h22E8};
    localparam logic [15:0] REG_MASK [NREG] = '{16'h01FF, 16'h00FF, 16'h00FF,
        16'h003F, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h003F, 16'h001E};
    localparam int SLOT_HTOT  = 0;
    localparam int SLOT_HDISP = 1;
    localparam int SLOT_HSS   = 2;
    localparam int SLOT_HSW   = 3;
    localparam int SLOT_VTOT  = 4;
    localparam int SLOT_VDISP = 5;
    localparam int SLOT_VSS   = 6;
    localparam int SLOT_VSW   = 7;
    localparam int SLOT_DCTL  = 8;

    localparam int POL_BIT   = 5;
    localparam int WID_MSB   = 4;
    localparam int ADJ_MSB   = 2;
    localparam int BASE_LSB  = 3;
    localparam int BASE_MSB  = 11;
    localparam int LPR_LSB   = 1;
    localparam int DBL_BIT   = 3;
    localparam int ILACE_BIT = 4;
    localparam int EN_LSB    = 5;
    localparam int VW        = 13;

    function automatic logic [4:0] cttg_scan_mod(input logic dbl,
                                                 input logic [1:0] lpr);
        logic [4:0] m;
        m = {2'b00, lpr, 1'b0} + 5'h02;
        return dbl ? {m[3:0], 1'b0} : m;
    endfunction

    function automatic logic [VW-1:0] cttg_vval(input logic [11:0] r,
                                                input logic [4:0] md);
        logic [VW:0] p;
        p = 14'(r[BASE_MSB:BASE_LSB] * md) + 14'(r[ADJ_MSB:0]) + 14'h0001;
        return p[VW-1:0];
    endfunction

endpackage

// file: design/cttg_pulse.sv
// Width-counted sync pulse, used for both horizontal and vertical sync.
// Assumes start and tick are one-cycle enables in the mclk_i domain.
`timescale 1ns/10ps
module cttg_pulse
    import cttg_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       tick_i,
    input  wire logic       start_i,
    input  wire logic [4:0] width_i,
    output logic            act_o
);
    logic [4:0] left_ff;
    logic [4:0] nxt_left;
    logic       act_ff;
    logic       nxt_act;

    // Only a new start or its own count ends the pulse, never a wrap
    assign nxt_left = start_i ? width_i
                    : (act_ff && tick_i) ? left_ff - 5'h01 : left_ff;
    assign nxt_act  = start_i ? (width_i != 5'h00)
                    : (act_ff && tick_i && left_ff == 5'h01) ? 1'b0
                    : act_ff;
    assign act_o    = act_ff;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            left_ff <= 5'h00;
            act_ff  <= 1'b0;
        end
        else
        begin
            left_ff <= nxt_left;
            act_ff  <= nxt_act;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_pulse_end: assert property ($fell(act_ff) |->
        $past(tick_i) && $past(left_ff) == 5'h01 || $past(start_i))
        else $error("sync pulse ended before its width ran out");
    a_pulse_load: assert property (start_i && width_i != 5'h00 |=> act_ff
        && left_ff == $past(width_i))
        else $error("sync pulse did not load its width");
endmodule // cttg_pulse

// file: design/cttg_regs.sv
// Host I/O register file of the timing generator, byte or word access.
// Assumes io_be_i[0] is the even-address byte and strobes last one cycle.
`timescale 1ns/10ps
module cttg_regs
    import cttg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [1:0]  io_be_i,
    input  wire logic [15:0] io_wdata_i,
    output logic      [15:0] io_rdata_o,
    output logic      [15:0] reg_o [NREG],
    output logic             disp_en_o
);
    logic [15:0] reg_ff [NREG];
    logic [15:0] rdata_ff;
    logic        en_ff;
    logic [15:0] lane_mask;
    logic [15:0] rd_mux;
    logic        ctl_wr;
    logic [1:0]  en_code;

    assign lane_mask = {{8{io_be_i[1]}}, {8{io_be_i[0]}}};
    assign ctl_wr    = io_wr_i && io_be_i[0] && io_addr_i == WR_ADDR[SLOT_DCTL];
    assign en_code   = io_wdata_i[EN_LSB+1:EN_LSB];

    always_comb
    begin
        rd_mux = 16'h0000;
        for (int i = 0; i < NREG; i++)
            if (io_addr_i == RD_ADDR[i])
                rd_mux = reg_ff[i];
        // Latch state reads in bit 5, bit 6 always zero
        if (io_addr_i == RD_ADDR[SLOT_DCTL])
            rd_mux[EN_LSB] = en_ff;
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < NREG; i++)
                reg_ff[i] <= RST_VAL;
            rdata_ff <= 16'h0000;
            en_ff    <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NREG; i++)
                if (io_wr_i && io_addr_i == WR_ADDR[i])
                    reg_ff[i] <= ((reg_ff[i] & ~lane_mask)
                        | (io_wdata_i & lane_mask)) & REG_MASK[i];
            if (io_rd_i)
                rdata_ff <= rd_mux;
            if (ctl_wr && en_code[1])
                en_ff <= 1'b0;
            else if (ctl_wr && en_code == 2'b01)
                en_ff <= 1'b1;
        end
    end

    assign io_rdata_o = rdata_ff;
    assign reg_o      = reg_ff;
    assign disp_en_o  = en_ff;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_en_latch: assert property (ctl_wr && en_code != 2'b00 |=>
        en_ff == !$past(en_code[1]))
        else $error("display enable latch missed its command");
    a_en_hold: assert property (!ctl_wr || en_code == 2'b00 |=>
        $stable(en_ff))
        else $error("display enable latch moved without a command");
    c_en_set: cover property (ctl_wr && en_code == 2'b01 ##1 en_ff);
endmodule // cttg_regs

// file: design/cttg_top.sv
// CRT timing generator: horizontal and vertical counters, blank and sync.
// Assumes mclk_i is the nugget clock and host I/O strobes are synchronous.
`timescale 1ns/10ps
module cttg_top
    import cttg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [2:0]  nugget_clock_divisor_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [1:0]  io_be_i,
    input  wire logic [15:0] io_wdata_i,
    output logic      [15:0] io_rdata_o,
    output logic             hblank_o,
    output logic             hsync_o,
    output logic             vblank_o,
    output logic             vsync_o,
    output logic             field_odd_o,
    output logic             disp_en_o
);
    logic [15:0]   regs [NREG];
    logic          en;

    cttg_regs u_regs (
        .mclk_i     (mclk_i),
        .srst_i     (srst_i),
        .io_addr_i  (io_addr_i),
        .io_wr_i    (io_wr_i),
        .io_rd_i    (io_rd_i),
        .io_be_i    (io_be_i),
        .io_wdata_i (io_wdata_i),
        .io_rdata_o (io_rdata_o),
        .reg_o      (regs),
        .disp_en_o  (en)
    );

    // Field views of the programmed registers
    logic [8:0]    htot;
    logic [8:0]    hdisp;
    logic [8:0]    hss;
    logic [4:0]    hsw;
    logic [4:0]    vsw;
    logic          hpol;
    logic          vpol;
    logic [1:0]    lpr;
    logic          dbl;
    logic          ilace;
    logic [4:0]    smod;
    logic [VW-1:0] vtot_v;
    logic [VW-1:0] vdisp_v;
    logic [VW-1:0] vss_v;

    assign htot    = regs[SLOT_HTOT][8:0];
    assign hdisp   = {1'b0, regs[SLOT_HDISP][7:0]};
    assign hss     = {1'b0, regs[SLOT_HSS][7:0]};
    assign hsw     = regs[SLOT_HSW][WID_MSB:0];
    assign hpol    = regs[SLOT_HSW][POL_BIT];
    assign vsw     = regs[SLOT_VSW][WID_MSB:0];
    assign vpol    = regs[SLOT_VSW][POL_BIT];
    assign lpr     = regs[SLOT_DCTL][LPR_LSB+1:LPR_LSB];
    assign dbl     = regs[SLOT_DCTL][DBL_BIT];
    assign ilace   = regs[SLOT_DCTL][ILACE_BIT];
    assign smod    = cttg_scan_mod(dbl, lpr);
    assign vtot_v  = cttg_vval(regs[SLOT_VTOT][11:0], smod);
    assign vdisp_v = cttg_vval(regs[SLOT_VDISP][11:0], smod);
    assign vss_v   = cttg_vval(regs[SLOT_VSS][11:0], smod);

    // Group divider: one tick per nugget_clock_divisor + 1 clocks
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    logic       tick;

    assign tick    = div_ff >= nugget_clock_divisor_i;
    assign nxt_div = tick ? 3'h0 : div_ff + 3'h1;

    // Horizontal counter
    logic [8:0] h_ff;
    logic [8:0] nxt_h;
    logic       line_end;
    logic       half_step;
    logic       vstep;

    assign line_end  = tick && h_ff >= htot;
    assign nxt_h     = line_end ? 9'h000
                     : tick ? h_ff + 9'h001 : h_ff;
    // Interlace adds a step at the half-line point of each line
    assign half_step = ilace && tick && !line_end
                    && h_ff == {1'b0, htot[8:1]};
    assign vstep     = line_end || half_step;

    // Vertical counter, in lines or half-lines
    logic [VW-1:0] v_ff;
    logic [VW-1:0] nxt_v;
    logic          v_last;

    assign v_last = v_ff >= vtot_v - 13'h0001;
    assign nxt_v  = !vstep ? v_ff
                  : v_last ? 13'h0000 : v_ff + 13'h0001;

    // Blank and sync decisions
    logic hblank_ff;
    logic nxt_hblank;
    logic vblank_ff;
    logic nxt_vblank;
    logic odd_ff;
    logic nxt_odd;
    logic hs_start;
    logic vs_start;
    logic hs_act;
    logic vs_act;

    assign nxt_hblank = line_end ? 1'b0
                      : (tick && h_ff == hdisp) ? 1'b1 : hblank_ff;
    assign hs_start   = tick && h_ff == hss && hss < htot;
    // Vblank only changes on a full line end, so in interlace the odd
    // field sees it half a line shorter and the even one half a line late
    assign nxt_vblank = line_end ? (nxt_v >= vdisp_v)
                      : vblank_ff;
    assign nxt_odd    = (vstep && v_last) ? (ilace && !odd_ff) : odd_ff;
    // Vsync starts on any step, half-line ones included
    assign vs_start   = vstep && nxt_v == vss_v;

    cttg_pulse u_hs (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .tick_i  (tick),
        .start_i (hs_start),
        .width_i (hsw),
        .act_o   (hs_act)
    );

    cttg_pulse u_vs (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .tick_i  (vstep),
        .start_i (vs_start),
        .width_i (vsw),
        .act_o   (vs_act)
    );

    // Registered pins; disabled display holds syncs idle and blanks
    logic hsync_ff;
    logic vsync_ff;
    logic hbo_ff;
    logic vbo_ff;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            div_ff    <= 3'h0;
            h_ff      <= 9'h000;
            v_ff      <= 13'h0000;
            hblank_ff <= 1'b0;
            vblank_ff <= 1'b0;
            odd_ff    <= 1'b0;
            hsync_ff  <= 1'b0;
            vsync_ff  <= 1'b0;
            hbo_ff    <= 1'b1;
            vbo_ff    <= 1'b1;
        end
        else
        begin
            div_ff    <= nxt_div;
            h_ff      <= nxt_h;
            v_ff      <= nxt_v;
            hblank_ff <= nxt_hblank;
            vblank_ff <= nxt_vblank;
            odd_ff    <= nxt_odd;
            hsync_ff  <= en ? (hs_act ^ hpol) : hpol;
            vsync_ff  <= en ? (vs_act ^ vpol) : vpol;
            hbo_ff    <= en ? hblank_ff : 1'b1;
            vbo_ff    <= en ? vblank_ff : 1'b1;
        end
    end

    assign hsync_o     = hsync_ff;
    assign vsync_o     = vsync_ff;
    assign hblank_o    = hbo_ff;
    assign vblank_o    = vbo_ff;
    assign field_odd_o = odd_ff;
    assign disp_en_o   = en;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_hblank_start: assert property (tick && h_ff == hdisp && !line_end
        |=> hblank_ff)
        else $error("horizontal blank did not start at displayed count");
    a_hblank_clear: assert property (line_end |=> !hblank_ff && h_ff == 0)
        else $error("line end did not clear blank and counter");
    a_hsync_gate: assert property ($rose(hs_act) |->
        $past(tick) && $past(h_ff) == $past(hss) && $past(hss < htot))
        else $error("horizontal sync began at the wrong count");
    a_hsync_span: assert property (line_end && hs_act && !hs_start
        && !(tick && u_hs.left_ff == 5'h01) |=> hs_act)
        else $error("line end cut the horizontal sync short");
    a_hsync_pol: assert property (en |=> hsync_o == $past(hs_act ^ hpol))
        else $error("horizontal sync polarity wrong");
    a_vstep_half: assert property (ilace && tick && !line_end
        && h_ff == {1'b0, htot[8:1]} |=> v_ff != $past(v_ff)
        || v_ff == 0)
        else $error("interlace half-line step missing");
    a_vstep_none: assert property (!ilace && !line_end |=> $stable(v_ff))
        else $error("vertical counter moved inside a line");
    a_vtot_wrap: assert property (vstep && v_ff == vtot_v - 13'h0001
        |=> v_ff == 0)
        else $error("vertical counter missed the total");
    a_scan_mod: assert property (smod == (dbl ? 5'h04 : 5'h02)
        * (5'h01 + {3'h0, lpr}))
        else $error("scan modulus wrong");
    a_vblank_align: assert property ($changed(vblank_ff) |->
        $past(line_end))
        else $error("vertical blank moved off a line end");
    a_vsync_start: assert property (vs_start && vsw != 5'h00 |=> vs_act)
        else $error("vertical sync did not start at its count");
    a_vsync_pol: assert property (en |=> vsync_o == $past(vs_act ^ vpol))
        else $error("vertical sync polarity wrong");
    a_off_idle: assert property (!en |=> hblank_o && vblank_o
        && hsync_o == $past(hpol))
        else $error("disabled display still drives timing");

    c_frame_wrap: cover property (vstep && v_last ##1 vblank_ff);
    c_ilace_vs:   cover property (ilace && half_step && vs_start);
    c_hs_span:    cover property (line_end && hs_act);
    c_odd_field:  cover property ($rose(odd_ff));
endmodule // cttg_top

// file: tb/cttg_meter.sv
// Monitor-side model of one sync or blank pin of the CRT and RAMDAC.
// Assumes an active-high pulse on sig_i, sampled on mclk_i.
`timescale 1ns/10ps
module cttg_meter
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        sig_i,
    output logic      [15:0] period_o,
    output logic      [15:0] width_o,
    output logic      [15:0] rises_o
);
    logic        sig_q;
    logic [15:0] since_ff;

    // Period is rise to rise, width is rise to fall, both in clocks
    always_ff @(posedge mclk_i)
    begin
        sig_q    <= sig_i;
        since_ff <= since_ff + 16'h0001;
        if (srst_i)
        begin
            rises_o <= 16'h0000;
        end
        else if (sig_i && !sig_q)
        begin
            period_o <= since_ff;
            since_ff <= 16'h0001;
            rises_o  <= rises_o + 16'h0001;
        end
        else if (!sig_i && sig_q)
        begin
            width_o <= since_ff;
        end
    end
endmodule // cttg_meter

// file: tb/testbench.sv
// Self-checking bench of the CRT timing generator and its host registers.
// Assumes cttg_meter instances stand in for the monitor on the pins.
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [15:0] wa;
        logic [1:0]  be;
        logic [15:0] wd;
        logic [15:0] ra;
        logic [15:0] ex0;
        logic [15:0] exp;
    } cttg_row_t;
    // Write port, lanes, data, read port, value before, value after
    localparam cttg_row_t ROWS [13] = '{
        '{16'h02E8, 2'h3, 16'hFFFF, 16'h26E8, 16'h0000, 16'h01FF},
        '{16'h06E8, 2'h3, 16'hFFFF, 16'h06E8, 16'h0000, 16'h00FF},
        '{16'h0AE8, 2'h3, 16'hFFFF, 16'h0AE8, 16'h0000, 16'h00FF},
        '{16'h0EE8, 2'h3, 16'hFFFF, 16'h0EE8, 16'h0000, 16'h003F},
        '{16'h12E8, 2'h3, 16'hFFFF, 16'h12E8, 16'h0000, 16'h0FFF},
        '{16'h16E8, 2'h3, 16'hFFFF, 16'h16E8, 16'h0000, 16'h0FFF},
        '{16'h1AE8, 2'h3, 16'hFFFF, 16'h1AE8, 16'h0000, 16'h0FFF},
        '{16'h1EE8, 2'h3, 16'hFFFF, 16'h1EE8, 16'h0000, 16'h003F},
        '{16'h22E8, 2'h3, 16'hFFFF, 16'h22E8, 16'h0000, 16'h001E},
        '{16'h12E8, 2'h1, 16'h001A, 16'h12E8, 16'h0FFF, 16'h0F1A},
        '{16'h12E8, 2'h2, 16'h0500, 16'h12E8, 16'h0F1A, 16'h051A},
        '{16'h3AE8, 2'h3, 16'hFFFF, 16'h3AE8, 16'h0000, 16'h0000},
        '{16'h22E8, 2'h1, 16'h0020, 16'h22E8, 16'h001E, 16'h0020}};
    // Modes in rising scan modulus, so the count never passes a new total
    localparam int ORD [8] = '{0, 1, 4, 2, 3, 5, 6, 7};

    logic        mclk_i;
    logic        srst_i;
    logic [2:0]  divisor;
    logic [15:0] io_addr, io_wdata, io_rdata, v;
    logic        io_wr, io_rd;
    logic [1:0]  io_be;
    logic        hblank, hsync, vblank, vsync, field_odd, disp_en, gap, f;
    logic [15:0] per [4];
    logic [15:0] wid [4];
    logic [15:0] ris [4];
    int          err_total, num_checks, cycles;

    // High from blank start to sync start, so its width is their distance
    assign gap = hblank & ~hsync;

    cttg_top u_cttg_top (.mclk_i(mclk_i), .srst_i(srst_i),
        .nugget_clock_divisor_i(divisor), .io_addr_i(io_addr),
        .io_wr_i(io_wr), .io_rd_i(io_rd), .io_be_i(io_be),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .hblank_o(hblank),
        .hsync_o(hsync), .vblank_o(vblank), .vsync_o(vsync),
        .field_odd_o(field_odd), .disp_en_o(disp_en));
    cttg_meter u_hs (.mclk_i(mclk_i), .srst_i(srst_i), .sig_i(hsync),
        .period_o(per[0]), .width_o(wid[0]), .rises_o(ris[0]));
    cttg_meter u_vs (.mclk_i(mclk_i), .srst_i(srst_i), .sig_i(vsync),
        .period_o(per[1]), .width_o(wid[1]), .rises_o(ris[1]));
    cttg_meter u_vb (.mclk_i(mclk_i), .srst_i(srst_i), .sig_i(vblank),
        .period_o(per[2]), .width_o(wid[2]), .rises_o(ris[2]));
    cttg_meter u_gp (.mclk_i(mclk_i), .srst_i(srst_i), .sig_i(gap),
        .period_o(per[3]), .width_o(wid[3]), .rises_o(ris[3]));

    task automatic conclude();
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        @(posedge mclk_i);
        io_addr  <= a;
        io_be    <= b;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge mclk_i);
        io_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge mclk_i);
        io_rd   <= 1'b0;
        #1 d = io_rdata;
    endtask

    // Bounded by the cycle ceiling below
    task automatic wait_vs(input int n);
        logic [15:0] c;
        c = ris[1];
        while (ris[1] != c + 16'(n))
            @(posedge mclk_i);
        #1;
    endtask

    // Counts low cycles of hsync (s=0) or vsync (s=1)
    task automatic cnt(input int s, input int n, output logic [15:0] k);
        k = 16'h0000;
        repeat (n)
        begin
            @(posedge mclk_i);
            #1 k = k + {15'h0000, (s ? vsync : hsync) == 1'b0};
        end
    endtask

    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        srst_i = 1'b1;
        divisor = 3'h1;
        io_addr = 16'h0000;
        io_wdata = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_be = 2'h3;
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        #1 chk("hblank", 16'h0001, 16'(hblank));
        chk("disp_en", 16'h0000, 16'(disp_en));
        foreach (ROWS[i])
        begin
            rd(ROWS[i].ra, v);
            chk("reg_before", ROWS[i].ex0, v);
            wr(ROWS[i].wa, ROWS[i].be, ROWS[i].wd);
            rd(ROWS[i].ra, v);
            chk("reg_after", ROWS[i].exp, v);
        end
        chk("disp_en", 16'h0001, 16'(disp_en));
        // Line of 10 groups of 2 clocks, sync runs past the line end
        wr(16'h02E8, 2'h3, 16'h0009);
        wr(16'h06E8, 2'h3, 16'h0005);
        wr(16'h0AE8, 2'h3, 16'h0006);
        wr(16'h0EE8, 2'h3, 16'h0005);
        wr(16'h12E8, 2'h3, 16'h001A);
        wr(16'h16E8, 2'h3, 16'h0011);
        wr(16'h1AE8, 2'h3, 16'h0010);
        wr(16'h1EE8, 2'h3, 16'h0002);
        wr(16'h22E8, 2'h1, 16'h0000);
        wait_vs(3);
        chk("line", 16'h0014, per[0]);
        chk("hs_width", 16'h000A, wid[0]);
        chk("hb_to_hs", 16'h0002, wid[3]);
        chk("frame", 16'h00B4, per[1]);
        chk("vs_width", 16'h0028, wid[1]);
        chk("vb_width", 16'h003C, wid[2]);
        chk("field", 16'h0000, 16'(field_odd));
        wr(16'h0EE8, 2'h1, 16'h0025);
        wr(16'h1EE8, 2'h1, 16'h0022);
        cnt(0, 20, v);
        chk("hs_low", 16'h000A, v);
        cnt(1, 180, v);
        chk("vs_low", 16'h0028, v);
        wr(16'h0EE8, 2'h1, 16'h0005);
        wr(16'h1EE8, 2'h1, 16'h0002);
        wr(16'h0AE8, 2'h1, 16'h0009);
        repeat (20) @(posedge mclk_i);
        cnt(0, 40, v);
        chk("hs_none", 16'h0028, v);
        wr(16'h0AE8, 2'h1, 16'h0006);
        // Even adjust gives an odd count of half lines
        wr(16'h12E8, 2'h3, 16'h0018);
        wr(16'h22E8, 2'h1, 16'h0010);
        wait_vs(3);
        chk("il_frame", 16'h0046, per[1]);
        chk("il_vs_width", 16'h0014, wid[1]);
        f = field_odd;
        wait_vs(1);
        chk("il_field", {15'h0000, ~f}, 16'(field_odd));
        wr(16'h12E8, 2'h3, 16'h001A);
        foreach (ORD[i])
        begin
            wr(16'h22E8, 2'h1, 16'(ORD[i] << 1));
            wait_vs(3);
            chk("mode_frame", 16'(((ORD[i] % 4) + 1) * (ORD[i] / 4 + 1)
                * 120 + 60), per[1]);
        end
        wr(16'h22E8, 2'h1, 16'h0040);
        repeat (2) @(posedge mclk_i);
        #1 chk("off_en", 16'h0000, 16'(disp_en));
        chk("off_blank", 16'h0001, 16'(hblank & vblank));
        rd(16'h22E8, v);
        chk("off_reg", 16'h0000, v);
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd(16'h06E8, v);
        chk("rst_reg", 16'h0000, v);
        conclude();
    end
endmodule // testbench
